// *** rtl/gfp_rx_delineator.sv ***
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ns
// Function
// R1 - find frames by header check correlation
// R2 - search tests last four octets, no correction
// R3 - first match in search enters tentative; code locks at once when match threshold is zero
// R4 - tentative checks only next presumed header
// R5 - enough consecutive matches enter locked state
// R6 - tentative mismatch returns to search
// R7 - locked follows lengths, fixes single-bit errors
// R8 - multi-bit error: lose sync, server fail
// R9 - idle frames counted, never forwarded
// R10 - match threshold configurable, default one
// R11 - parallel tentative framers optional, not built
// R12 - check sequence crc-32, preset all ones
// R13 - covers payload area octets, msb first
// R14 - remainder inverted forms sent check value
// R15 - receiver accepts on fixed residue
// R16 - client fail: user control type, code
// R17 - source sends client fail about once/second
// R18 - clear client fail after missed indications
// R19 - server fail on trail fail, lock clears
// R20 - undefined extension fields are zero
// R21 - linear header: dest port, source port, spare
// R22 - extension check covers extension octets only
// R23 - header check x16+x12+x5+1, zero preset
// R24 - remove header xor pattern before checking
// R25 - descramble only locked payload, keep state
// R26 - next header at start+4+length
module gfp_rx_delineator
  import gfp_rx_pkg::*;
#(
  parameter int unsigned CSF_PERIOD = CSF_PERIOD_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  input  wire logic        trail_fail_event,
  output logic      [7:0]  out_data,
  output logic             out_valid,
  output logic             out_sof,
  output logic             out_eof,
  output logic             frame_fcs_ok,
  output logic             server_fail_indication,
  output logic             client_fail_indication,
  output logic             client_fail_code,
  output logic      [3:0]  destination_port_field,
  output logic      [3:0]  source_port_field,
  output logic             locked
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] hec16(input logic [15:0] d);
    logic [15:0] c;
    c = HEC_PRESET; // R23
    for (int i = 15; i >= 0; i--) begin
      if (c[15] ^ d[i]) c = {c[14:0], 1'b0} ^ HEC_POLY;
      else c = {c[14:0], 1'b0};
    end
    return c;
  endfunction
  function automatic logic [31:0] fcs8(input logic [31:0] c_in, input logic [7:0] d);
    logic [31:0] c;
    c = c_in;
    for (int i = 7; i >= 0; i--) begin // R13
      if (c[31] ^ d[i]) c = {c[30:0], 1'b0} ^ FCS_POLY; // R12
      else c = {c[30:0], 1'b0};
    end
    return c;
  endfunction
  // syndrome of each single-bit error; constant tables after synthesis
  function automatic logic [32:0] fix_mask(input logic [15:0] syn);
    logic [31:0] e;
    logic [32:0] r;
    r = '0;
    for (int i = 0; i < 32; i++) begin
      e = 32'h1 << i;
      if ((hec16(e[31:16]) ^ e[15:0]) == syn) r = {1'b1, e};
    end
    return r;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  dlin_state_t           state_r;
  logic [31:0]           win_r;
  logic [16:0]           cnt_r;
  logic [3:0]            mcnt_r;
  logic [DSCR_LEN-1:0]   dscr_r;
  logic [15:0]           idx_r;
  logic [31:0]           fcs_r;
  logic [2:0]            pti_r;
  logic                  pfi_r;
  logic [3:0]            exi_r;
  logic [7:0]            upi_r;
  logic [23:0]           ext_r;
  logic [3:0]            delta_r;
  logic [3:0]            ncsf_r;
  logic [3:0]            miss_r;
  logic [31:0]           sec_r;
  logic                  seen_r;
  logic                  fcs_err_r;
  logic                  extension_header_check_err_r;
  logic [15:0]           idle_cnt_r;
  logic [15:0]           fcse_cnt_r;
  logic [31:0]           win_nxt;
  logic [31:0]           hdr;
  logic [15:0]           syn;
  logic [32:0]           fix;
  logic [15:0]           payload_length_field;
  logic                  hdr_pt;
  logic                  hdr_ok;
  logic                  hdr_fixable;
  logic                  pl;
  logic                  last;
  logic [7:0]            oct;
  logic [DSCR_LEN-1:0]   dscr_nxt;
  logic [31:0]           fcs_nxt;
  logic                  fcs_good;
  logic                  csf_frame;
  logic                  sec_tick;
  always_comb begin
    win_nxt = {win_r[23:0], rx_data};
    hdr = win_nxt ^ CORE_HDR_XOR; // R24
    syn = hec16(hdr[31:16]) ^ hdr[15:0]; // R1
    fix = fix_mask(syn);
    hdr_ok = (syn == 16'h0000);
    // correction is only honoured in the locked state
    hdr_fixable = (state_r == ST_LOCK) && fix[32]; // R7
    payload_length_field = hdr_ok ? hdr[31:16] : hdr[31:16] ^ fix[31:16];
    hdr_pt = rx_valid && (state_r == ST_SEARCH || cnt_r == 17'h00000); // R2 R4
    pl = rx_valid && (state_r == ST_LOCK) && (cnt_r > HDR_TAIL);
    last = pl && (cnt_r == HDR_LEN);
    dscr_nxt = dscr_r;
    for (int i = 7; i >= 0; i--) begin // R25
      oct[i] = rx_data[i] ^ dscr_nxt[DSCR_LEN-1];
      dscr_nxt = {dscr_nxt[DSCR_LEN-2:0], rx_data[i]};
    end
    fcs_nxt = fcs8(fcs_r, oct);
    fcs_good = !pfi_r || (fcs_nxt == FCS_RESIDUE); // R14 R15
    csf_frame = last && fcs_good && (pti_r == PTI_USER_CTRL); // R16
    sec_tick = (sec_r == CSF_PERIOD - 1);
  end
  ////////////////////////////////////////////////////////////////////////////
  // delineation state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_SEARCH;
      cnt_r <= '0;
      mcnt_r <= '0;
    end else if (rx_valid) begin
      cnt_r <= cnt_r - 17'h00001;
      case (state_r)
        ST_SEARCH: begin // R11
          if (hdr_ok) begin // R3
            state_r <= (delta_r == 4'h0) ? ST_LOCK : ST_TENT;
            cnt_r <= {1'b0, payload_length_field} + HDR_TAIL; // R26
            mcnt_r <= 4'h0;
          end
        end
        ST_TENT: begin
          if (hdr_pt) begin
            if (hdr_ok) begin
              cnt_r <= {1'b0, payload_length_field} + HDR_TAIL; // R26
              mcnt_r <= mcnt_r + 4'h1;
              if (mcnt_r + 4'h1 >= delta_r) state_r <= ST_LOCK; // R5 R10
            end else begin
              state_r <= ST_SEARCH; // R6
            end
          end
        end
        ST_LOCK: begin
          if (hdr_pt) begin
            if (hdr_ok || hdr_fixable) cnt_r <= {1'b0, payload_length_field} + HDR_TAIL; // R7
            else state_r <= ST_SEARCH; // R8
          end
        end
        default: state_r <= ST_SEARCH;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // payload area: descrambler, index, check sequence, header fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_r <= '0;
      dscr_r <= '0;
    end else if (rx_valid) begin
      win_r <= win_nxt;
      if (pl) dscr_r <= dscr_nxt; // R25
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_r <= '0;
      fcs_r <= FCS_PRESET;
      pti_r <= '0;
      pfi_r <= 1'b0;
      exi_r <= '0;
      upi_r <= '0;
      ext_r <= '0;
      extension_header_check_err_r <= 1'b0;
    end else if (hdr_pt && state_r == ST_LOCK) begin
      idx_r <= '0;
      fcs_r <= FCS_PRESET; // R12 R15
    end else if (pl) begin
      idx_r <= idx_r + 16'h0001;
      fcs_r <= fcs_nxt; // R13
      case (idx_r)
        IDX_TYPE_HI: {pti_r, pfi_r, exi_r} <= oct;
        IDX_TYPE_LO: upi_r <= oct;
        IDX_EXT_PORTS: ext_r[23:16] <= oct; // R21
        IDX_EXT_SPARE: ext_r[15:8] <= oct;
        IDX_EXTENSION_HEADER_CHECK_HI: ext_r[7:0] <= oct;
        IDX_EXTENSION_HEADER_CHECK_LO: begin
          // only the extension octets feed this check, not type or its check
          if (exi_r == EXI_LINEAR) extension_header_check_err_r <= (hec16(ext_r[23:8]) != {ext_r[7:0], oct}); // R22
        end
        default: ;
      endcase
    end
  end
  // received spare bits are read back unchecked; defined fields expose zero when absent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      destination_port_field <= '0;
      source_port_field <= '0;
    end else if (last && exi_r == EXI_LINEAR && !extension_header_check_err_r) begin
      destination_port_field <= ext_r[23:20]; // R21
      source_port_field <= ext_r[19:16];
    end else if (last && exi_r != EXI_LINEAR) begin
      destination_port_field <= '0; // R20
      source_port_field <= '0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // client stream out; idle frames carry no payload so nothing leaves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_data <= '0;
      out_valid <= 1'b0;
      out_sof <= 1'b0;
      out_eof <= 1'b0;
      frame_fcs_ok <= 1'b0;
      fcs_err_r <= 1'b0;
    end else begin
      out_valid <= pl; // R9
      out_data <= pl ? oct : 8'h00;
      out_sof <= pl && (idx_r == IDX_TYPE_HI);
      out_eof <= last;
      frame_fcs_ok <= last && fcs_good; // R15
      if (last) fcs_err_r <= !fcs_good;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_r <= '0;
      fcse_cnt_r <= '0;
    end else begin
      if (hdr_pt && state_r == ST_LOCK && (hdr_ok || hdr_fixable) && payload_length_field == 16'h0000) begin
        idle_cnt_r <= idle_cnt_r + 16'h0001; // R9
      end
      if (last && !fcs_good) fcse_cnt_r <= fcse_cnt_r + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // server fail: raised by trail fail or sync loss, dropped in any other cycle spent in the locked state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      server_fail_indication <= 1'b0;
      locked <= 1'b0;
    end else begin
      locked <= (state_r == ST_LOCK);
      if (trail_fail_event || (hdr_pt && state_r == ST_LOCK && !hdr_ok && !hdr_fixable)) begin
        server_fail_indication <= 1'b1; // R8 R19
      end else if (state_r == ST_LOCK) begin
        server_fail_indication <= 1'b0; // R19
      end
    end
  end
  // client fail defect; expected once per period, cleared after ncsf misses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_r <= '0;
      seen_r <= 1'b0;
      miss_r <= '0;
      client_fail_indication <= 1'b0;
      client_fail_code <= 1'b0;
    end else begin
      sec_r <= sec_tick ? 32'h00000000 : sec_r + 32'h00000001; // R17
      if (csf_frame) begin
        client_fail_indication <= 1'b1; // R16
        client_fail_code <= (upi_r == CSF_LOSS_SYNC);
        seen_r <= 1'b1;
        miss_r <= '0;
      end else if (sec_tick) begin
        seen_r <= 1'b0;
        if (!seen_r && client_fail_indication) begin
          if (miss_r + 4'h1 >= ncsf_r) begin
            client_fail_indication <= 1'b0; // R18
            miss_r <= '0;
          end else begin
            miss_r <= miss_r + 4'h1;
          end
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state
  logic [31:0] rd_val;
  logic        rd_hit;
  logic [1:0]  st_code;
  always_comb begin
    case (state_r)
      ST_TENT: st_code = 2'h1;
      ST_LOCK: st_code = 2'h2;
      default: st_code = 2'h0;
    endcase
    rd_val = '0;
    rd_hit = 1'b1;
    case (paddr)
      ADDR_CTRL: begin
        rd_val[CTRL_DELTA_LSB +: 4] = delta_r;
        rd_val[CTRL_NCSF_LSB +: 4] = ncsf_r;
      end
      ADDR_STATUS: begin
        rd_val[ST_STATE_LSB +: 2] = st_code;
        rd_val[ST_SF_BIT] = server_fail_indication;
        rd_val[ST_CSF_BIT] = client_fail_indication;
        rd_val[ST_CSFC_BIT] = client_fail_code;
        rd_val[ST_FCSE_BIT] = fcs_err_r;
        rd_val[ST_EHECE_BIT] = extension_header_check_err_r;
      end
      ADDR_COUNTS: rd_val = {fcse_cnt_r, idle_cnt_r};
      ADDR_EXT: begin
        rd_val[3:0] = destination_port_field;
        rd_val[EXT_SP_LSB +: 4] = source_port_field;
        rd_val[EXT_SPARE_LSB +: 8] = ext_r[15:8];
      end
      default: rd_hit = 1'b0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      prdata <= (psel && penable && !pready && !pwrite) ? rd_val : 32'h00000000;
      pslverr <= psel && penable && !pready && !rd_hit;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delta_r <= DELTA_RST; // R10
      ncsf_r <= NCSF_RST;
    end else if (psel && penable && pready && pwrite && paddr == ADDR_CTRL) begin
      delta_r <= pwdata[CTRL_DELTA_LSB +: 4];
      ncsf_r <= pwdata[CTRL_NCSF_LSB +: 4];
    end
  end
endmodule

// *** include/gfp_rx_pkg.sv ***
package gfp_rx_pkg;
  // core header and check polynomials
  localparam logic [31:0] CORE_HDR_XOR   = 32'hB6AB31E0;
  localparam logic [15:0] HEC_POLY       = 16'h1021;
  localparam logic [15:0] HEC_PRESET     = 16'h0000;
  localparam logic [31:0] FCS_POLY       = 32'h04C11DB7;
  localparam logic [31:0] FCS_PRESET     = 32'hFFFFFFFF;
  localparam logic [31:0] FCS_RESIDUE    = 32'hC704DD7B;
  localparam int          DSCR_LEN       = 43;
  // core header: octets that follow its first octet, then its full length in octets
  localparam logic [16:0] HDR_TAIL       = 17'h00003;
  localparam logic [16:0] HDR_LEN        = 17'h00004;
  // payload header layout, as octet index within the payload area
  localparam logic [15:0] IDX_TYPE_HI    = 16'h0000;
  localparam logic [15:0] IDX_TYPE_LO    = 16'h0001;
  localparam logic [15:0] IDX_EXT_PORTS  = 16'h0004;
  localparam logic [15:0] IDX_EXT_SPARE  = 16'h0005;
  localparam logic [15:0] IDX_EXTENSION_HEADER_CHECK_HI    = 16'h0006;
  localparam logic [15:0] IDX_EXTENSION_HEADER_CHECK_LO    = 16'h0007;
  localparam logic [2:0]  PTI_USER_DATA  = 3'h0;
  localparam logic [2:0]  PTI_USER_CTRL  = 3'h1;
  localparam logic [3:0]  EXI_LINEAR     = 4'h1;
  localparam logic [7:0]  CSF_LOSS_SIG   = 8'h00;
  localparam logic [7:0]  CSF_LOSS_SYNC  = 8'h01;
  // register map
  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_STATUS    = 12'h004;
  localparam logic [11:0] ADDR_COUNTS    = 12'h008;
  localparam logic [11:0] ADDR_EXT       = 12'h00C;
  localparam int          CTRL_DELTA_LSB = 0;
  localparam int          CTRL_NCSF_LSB  = 4;
  localparam logic [3:0]  DELTA_RST      = 4'h1;
  localparam logic [3:0]  NCSF_RST       = 4'h3;
  localparam int          ST_STATE_LSB   = 0;
  localparam int          ST_SF_BIT      = 2;
  localparam int          ST_CSF_BIT     = 3;
  localparam int          ST_CSFC_BIT    = 4;
  localparam int          ST_FCSE_BIT    = 5;
  localparam int          ST_EHECE_BIT   = 6;
  localparam int          CNT_FCSE_LSB   = 16;
  localparam int          EXT_SP_LSB     = 4;
  localparam int          EXT_SPARE_LSB  = 8;
  // client-fail indication spacing
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned CSF_PERIOD_MS  = 1000;
  localparam int unsigned CSF_PERIOD_CYC = CSF_PERIOD_MS * 1000 * CLK_MHZ;

  typedef enum logic [1:0] {ST_SEARCH, ST_TENT, ST_LOCK} dlin_state_t;
endpackage

// *** dv/gfp_rx_monitor.sv ***
`timescale 1ns/1ns
module gfp_rx_monitor
  import gfp_rx_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        trail_fail_event,
  input wire logic        out_valid,
  input wire logic        out_sof,
  input wire logic        out_eof,
  input wire logic        frame_fcs_ok,
  input wire logic        server_fail_indication,
  input wire logic        locked
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic unmapped;
  assign unmapped = !(paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_COUNTS, ADDR_EXT});
  //////////////////////////////////////////////////////////////////////////////
  apb_answer_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one cycle pulse");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_decode_a: assert property (psel && penable && !pready |=> pslverr == unmapped)
    else $error("error flag does not match decode");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h00000000)
    else $error("read data outside answer");
  fwd_locked_a: assert property (out_valid |-> locked)
    else $error("octet forwarded while not locked");
  marks_valid_a: assert property ((out_sof || out_eof) |-> out_valid)
    else $error("frame mark without octet");
  fcs_eof_a: assert property (frame_fcs_ok |-> out_eof)
    else $error("check result off frame end");
  trail_sf_a: assert property (trail_fail_event |=> server_fail_indication)
    else $error("trail fail not raised");
  loss_sf_a: assert property ($fell(locked) |-> server_fail_indication)
    else $error("sync loss without server fail");
  lock_clear_a: assert property (!trail_fail_event ##1 locked ##1 locked |-> !$past(server_fail_indication))
    else $error("server fail stuck in lock");
  cover property ($rose(locked));
  cover property (frame_fcs_ok);
  cover property (pslverr);
  cover property (server_fail_indication && !locked);
endmodule
bind gfp_rx_delineator gfp_rx_monitor gfp_rx_monitor_inst (.pclk, .presetn, .paddr, .psel, .penable, .prdata,
  .pready, .pslverr, .trail_fail_event, .out_valid, .out_sof, .out_eof, .frame_fcs_ok, .server_fail_indication,
  .locked);

// *** dv/gfp_tx_model.sv ***
`timescale 1ns/1ns
module gfp_tx_model
  import gfp_rx_pkg::*;
(
  input  wire logic       pclk,
  output logic      [7:0] rx_data,
  output logic            rx_valid
);
  logic [42:0] scr_r;
  logic [31:0] fcs_r;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'h0;
    scr_r = '0;
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'h0} ^ ((c[15] ^ d[i]) ? HEC_POLY : 16'h0000);
    return c;
  endfunction
  function automatic logic [31:0] crc32(input logic [31:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) c = {c[30:0], 1'h0} ^ ((c[31] ^ d[i]) ? FCS_POLY : 32'h00000000);
    return c;
  endfunction
  task automatic put(input logic [7:0] d);
    @(posedge pclk);
    rx_data <= d;
    rx_valid <= 1'h1;
  endtask
  // released line shows the inverse so a stale octet is never mistaken for data
  task automatic gap();
    @(posedge pclk);
    rx_valid <= 1'h0;
    rx_data <= ~rx_data;
  endtask
  task automatic send_hdr(input logic [15:0] len, input logic [31:0] flip);
    logic [31:0] w;
    w = {len, crc16(crc16(HEC_PRESET, len[15:8]), len[7:0])} ^ CORE_HDR_XOR ^ flip;
    for (int i = 3; i >= 0; i--) put(w[8*i+:8]);
    gap();
  endtask
  task automatic put_pl(input logic [7:0] d, input logic add);
    logic [7:0] s;
    if (add) fcs_r = crc32(fcs_r, d);
    for (int i = 7; i >= 0; i--) begin
      s[i] = d[i] ^ scr_r[42];
      scr_r = {scr_r[41:0], s[i]};
    end
    put(s);
  endtask
  task automatic send_frame(input logic [2:0] payload_type_field, input logic [7:0] upi, input logic [3:0] exi,
                            input logic [7:0] ports, input int n, input logic [31:0] flip, input logic bad);
    logic [7:0]  t;
    logic [15:0] h;
    logic [31:0] f;
    t = {payload_type_field, 1'h1, exi};
    send_hdr(16'(8 + n + ((exi == EXI_LINEAR) ? 4 : 0)), flip);
    fcs_r = FCS_PRESET;
    h = crc16(crc16(HEC_PRESET, t), upi);
    put_pl(t, 1'h1);
    put_pl(upi, 1'h1);
    put_pl(h[15:8], 1'h1);
    put_pl(h[7:0], 1'h1);
    if (exi == EXI_LINEAR) begin
      h = crc16(crc16(HEC_PRESET, ports), 8'h00);
      put_pl(ports, 1'h1);
      put_pl(8'h00, 1'h1);
      put_pl(h[15:8], 1'h1);
      put_pl(h[7:0], 1'h1);
    end
    for (int i = 0; i < n; i++) put_pl(8'hA0 + 8'(i), 1'h1);
    f = ~fcs_r ^ {31'h0, bad};
    for (int i = 3; i >= 0; i--) put_pl(f[8*i+:8], 1'h0);
    gap();
  endtask
endmodule

// *** dv/gfp_rx_delineator_tb.sv ***
`timescale 1ns/1ns
module gfp_rx_delineator_tb
  import gfp_rx_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_valid, trail_fail_event;
  logic        out_valid, out_sof, out_eof, frame_fcs_ok, server_fail_indication;
  logic        client_fail_indication, client_fail_code, locked, er, fok_r;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, c0;
  logic [7:0]  rx_data, out_data, sof_r;
  logic [3:0]  destination_port_field, source_port_field;
  logic [7:0]  oq[$];
  int          err_total, compares;
  gfp_rx_delineator #(.CSF_PERIOD(64)) gfp_rx_delineator_inst (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .rx_data, .rx_valid, .trail_fail_event, .out_data,
    .out_valid, .out_sof, .out_eof, .frame_fcs_ok, .server_fail_indication, .client_fail_indication,
    .client_fail_code, .destination_port_field, .source_port_field, .locked);
  gfp_tx_model gfp_tx_model_inst (.pclk, .rx_data, .rx_valid);
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (out_valid === 1'h1) oq.push_back(out_data);
    if (out_eof === 1'h1) fok_r <= frame_fcs_ok;
    if (out_sof === 1'h1) sof_r <= out_data;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s seen %h want %h", $time, msg, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, wd};
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
    if (pready !== 1'h1) begin
      err_total++;
      final_report();
    end
  endtask
  task automatic st(input logic [1:0] exp);
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk(rd[1:0], exp, "state");
  endtask
  task automatic t_regs();
    apb(1'h0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h00000031, "ctrl reset");
    apb(1'h0, 12'h010, 32'h0);
    chk(er, 1'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    apb(1'h1, ADDR_STATUS, 32'hFFFFFFFF);
    st(2'h0);
    apb(1'h1, ADDR_CTRL, 32'h00000032);
    $display("test regs done");
  endtask
  task automatic t_sync();
    // odd junk first so the first header is off any fixed alignment
    for (int i = 0; i < 3; i++) gfp_tx_model_inst.put(8'h12 + 8'(i));
    gfp_tx_model_inst.send_hdr(16'h0, 32'h0);
    st(2'h1);
    gfp_tx_model_inst.send_hdr(16'h0, 32'h00000001);
    st(2'h0);
    gfp_tx_model_inst.send_hdr(16'h0, 32'h0);
    gfp_tx_model_inst.send_hdr(16'h0, 32'h0);
    st(2'h1);
    chk(locked, 1'h0, "early lock");
    gfp_tx_model_inst.send_hdr(16'h0, 32'h0);
    st(2'h2);
    chk(locked, 1'h1, "lock");
    $display("test sync done");
  endtask
  task automatic t_idle();
    apb(1'h0, ADDR_COUNTS, 32'h0);
    c0 = rd;
    gfp_tx_model_inst.send_hdr(16'h0, 32'h0);
    gfp_tx_model_inst.send_hdr(16'h0, 32'h0);
    apb(1'h0, ADDR_COUNTS, 32'h0);
    chk(rd[15:0], c0[15:0] + 16'h2, "idle count");
    chk(oq.size(), 0, "idle forwarded");
    $display("test idle done");
  endtask
  task automatic t_data();
    // length bit flipped: only correction in lock keeps the framing
    gfp_tx_model_inst.send_frame(PTI_USER_DATA, 8'h00, EXI_LINEAR, 8'h5C, 4, 32'h00010000, 1'h0);
    repeat (3) @(posedge pclk);
    chk(oq.size(), 16, "octets");
    chk({oq[0], oq[8], oq[11]}, 24'h11A0A3, "payload");
    chk(sof_r, 8'h11, "sof");
    chk(fok_r, 1'h1, "fcs good");
    chk({destination_port_field, source_port_field}, 8'h5C, "ports");
    gfp_tx_model_inst.send_frame(PTI_USER_DATA, 8'h00, 4'h0, 8'h00, 2, 32'h0, 1'h1);
    repeat (3) @(posedge pclk);
    chk(fok_r, 1'h0, "fcs bad");
    st(2'h2);
    chk(rd[ST_FCSE_BIT], 1'h1, "fcs flag");
    $display("test data done");
  endtask
  task automatic t_csf();
    for (int c = 1; c >= 0; c--) begin
      gfp_tx_model_inst.send_frame(PTI_USER_CTRL, 8'(c), 4'h0, 8'h00, 0, 32'h0, 1'h0);
      repeat (3) @(posedge pclk);
      chk({client_fail_indication, client_fail_code}, {1'h1, 1'(c)}, "csf set");
      repeat (100) @(posedge pclk);
      chk(client_fail_indication, 1'h1, "csf early clear");
      repeat (160) @(posedge pclk);
      chk(client_fail_indication, 1'h0, "csf clear");
    end
    $display("test csf done");
  endtask
  task automatic t_sf();
    trail_fail_event <= 1'h1;
    repeat (3) @(posedge pclk);
    chk(server_fail_indication, 1'h1, "trail fail");
    trail_fail_event <= 1'h0;
    repeat (3) @(posedge pclk);
    chk(server_fail_indication, 1'h0, "trail clear");
    gfp_tx_model_inst.send_hdr(16'h0, 32'h00000003);
    repeat (2) @(posedge pclk);
    chk({server_fail_indication, locked}, 2'h2, "sync loss");
    st(2'h0);
    for (int i = 0; i < 3; i++) gfp_tx_model_inst.send_hdr(16'h0, 32'h0);
    repeat (3) @(posedge pclk);
    chk({server_fail_indication, locked}, 2'h1, "relock");
    $display("test sf done");
  endtask
  initial begin
    {presetn, psel, penable, pwrite, trail_fail_event, fok_r} = 6'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_sync();
    t_idle();
    t_data();
    t_csf();
    t_sf();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    final_report();
  end
endmodule
